// [mio_pkg.sv]
// Package: constants, types and helpers for the memory-mapped port block
// Functional notes
// - All seven port groups decode at FF0H to FF6H in data memory bank 15.
// - Twenty-four pins: six input-only, eighteen configurable, eight of them high-current.
// - Every port latch is writable at its own address; reads and bit tests there show it on output pins only.
// - Ports zero and three are 3-bit, accessed per bit or all three together.
// - Ports zero, three, six: software pull-ups on inputs, forced off on outputs.
// - Bidirectional port pins each pick input or output under software control.
// - Port one is a 2-bit input port, bit or pair access, software pull-ups.
// - Port two is a 4-bit input port, bit or nibble read; writes do nothing.
// - Ports four and five take 1-, 4- or 8-bit access; 8-bit covers both.
// - Ports four and five: one pull-up select per 4-pin group, off on outputs.
// - Ports four and five: per-pin open-drain or push-pull output selection.
// - Port six is 4-bit bidirectional, accessed per bit or as a nibble.
package mio_pkg;

  typedef enum logic [1:0] {MIO_W1, MIO_W4, MIO_W8} mio_width_t;

  localparam int PIN_IN_W = 24;
  localparam int P0_W = 3;
  localparam int P1_W = 2;
  localparam int P2_W = 4;
  localparam int P3_W = 3;
  localparam int P4_W = 4;
  localparam int P5_W = 4;
  localparam int P6_W = 4;
  localparam int P0_LSB = 0;
  localparam int P1_LSB = 3;
  localparam int P2_LSB = 5;
  localparam int P3_LSB = 9;
  localparam int P4_LSB = 12;
  localparam int P5_LSB = 16;
  localparam int P6_LSB = 20;

  localparam logic [11:0] ADDR_PORT0 = 12'hFF0;
  localparam logic [11:0] ADDR_PORT1 = 12'hFF1;
  localparam logic [11:0] ADDR_PORT2 = 12'hFF2;
  localparam logic [11:0] ADDR_PORT3 = 12'hFF3;
  localparam logic [11:0] ADDR_PORT4 = 12'hFF4;
  localparam logic [11:0] ADDR_PORT5 = 12'hFF5;
  localparam logic [11:0] ADDR_PORT6 = 12'hFF6;
  localparam logic [11:0] ADDR_DIR0 = 12'hFE0;
  localparam logic [11:0] ADDR_DIR3 = 12'hFE1;
  localparam logic [11:0] ADDR_DIR4 = 12'hFE2;
  localparam logic [11:0] ADDR_DIR5 = 12'hFE3;
  localparam logic [11:0] ADDR_DIR6 = 12'hFE4;
  localparam logic [11:0] ADDR_PU0 = 12'hFE5;
  localparam logic [11:0] ADDR_PU1 = 12'hFE6;
  localparam logic [11:0] ADDR_PU3 = 12'hFE7;
  localparam logic [11:0] ADDR_PU45 = 12'hFE8;
  localparam logic [11:0] ADDR_PU6 = 12'hFE9;
  localparam logic [11:0] ADDR_OD4 = 12'hFEA;
  localparam logic [11:0] ADDR_OD5 = 12'hFEB;

  localparam int NUM_SLOTS = 19;
  localparam logic [4:0] S_P0 = 5'h00;
  localparam logic [4:0] S_P1 = 5'h01;
  localparam logic [4:0] S_P2 = 5'h02;
  localparam logic [4:0] S_P3 = 5'h03;
  localparam logic [4:0] S_P4 = 5'h04;
  localparam logic [4:0] S_P5 = 5'h05;
  localparam logic [4:0] S_P6 = 5'h06;
  localparam logic [4:0] S_DIR0 = 5'h07;
  localparam logic [4:0] S_DIR3 = 5'h08;
  localparam logic [4:0] S_DIR4 = 5'h09;
  localparam logic [4:0] S_DIR5 = 5'h0A;
  localparam logic [4:0] S_DIR6 = 5'h0B;
  localparam logic [4:0] S_PU0 = 5'h0C;
  localparam logic [4:0] S_PU1 = 5'h0D;
  localparam logic [4:0] S_PU3 = 5'h0E;
  localparam logic [4:0] S_PU45 = 5'h0F;
  localparam logic [4:0] S_PU6 = 5'h10;
  localparam logic [4:0] S_OD4 = 5'h11;
  localparam logic [4:0] S_OD5 = 5'h12;
  localparam logic [4:0] SLOT_NONE = 5'h1F;

  // Implemented bits per slot; input-only ports hold no storage
  localparam logic [3:0] SLOT_MASK [NUM_SLOTS] = '{
    4'h7, 4'h0, 4'h0, 4'h7, 4'hF, 4'hF, 4'hF,
    4'h7, 4'h7, 4'hF, 4'hF, 4'hF,
    4'h7, 4'h3, 4'h7, 4'h3, 4'hF, 4'hF, 4'hF};
  localparam logic [3:0] REG_RST = 4'h0;
  localparam int PU45_GRP4_BIT = 0;
  localparam int PU45_GRP5_BIT = 1;

  function automatic logic [4:0] addr_slot(input logic [11:0] a);
    logic [4:0] s;
    s = SLOT_NONE;
    if (a >= ADDR_PORT0 && a <= ADDR_PORT6) begin
      s = 5'(a - ADDR_PORT0);
    end else if (a >= ADDR_DIR0 && a <= ADDR_OD5) begin
      s = 5'(a - ADDR_DIR0) + S_DIR0;
    end
    return s;
  endfunction : addr_slot

  function automatic logic [3:0] apply_write(input logic [3:0] old, input mio_width_t w,
                                             input logic [1:0] bsel, input logic [3:0] d,
                                             input logic [3:0] mask);
    logic [3:0] r;
    r = old;
    if (w == MIO_W1) begin
      r[bsel] = d[0];
    end else begin
      r = d;
    end
    return r & mask;
  endfunction : apply_write

  function automatic logic [3:0] port_rd(input logic [3:0] lat, input logic [3:0] dir,
                                         input logic [3:0] pin);
    return (dir & lat) | (~dir & pin);
  endfunction : port_rd

endpackage : mio_pkg

// [mio_sync.sv]
// Two-stage synchroniser for all pin inputs
`timescale 1ns/1ps
`default_nettype none
module mio_sync (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [mio_pkg::PIN_IN_W-1:0] pin_raw,
  output logic [mio_pkg::PIN_IN_W-1:0] pin_sync
);
  logic [mio_pkg::PIN_IN_W-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_r <= '0;
      pin_sync <= '0;
    end else begin
      meta_r <= pin_raw;
      pin_sync <= meta_r;
    end
  end
endmodule : mio_sync
`default_nettype wire

// [mio_pin_drv.sv]
// Registered output driver and pull-up control for one bidirectional port
`timescale 1ns/1ps
`default_nettype none
module mio_pin_drv #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] pu_sel,
  input wire logic [W-1:0] od_sel,
  output logic [W-1:0] pin_out,
  output logic [W-1:0] pin_oe,
  output logic [W-1:0] pu_out
);
  logic [W-1:0] out_nxt;
  logic [W-1:0] oe_nxt;
  logic [W-1:0] pu_nxt;

  // Open-drain only sinks; a high latch releases the pin to the board
  assign out_nxt = latch & ~od_sel;
  assign oe_nxt = dir & ~(od_sel & latch);
  // Pull-up never fights the driver of an output pin
  assign pu_nxt = pu_sel & ~dir;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pin_out <= '0;
      pin_oe <= '0;
      pu_out <= '0;
    end else begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
      pu_out <= pu_nxt;
    end
  end
endmodule : mio_pin_drv
`default_nettype wire

// [mio_ports.sv]
// Top of the seven memory-mapped parallel ports with their register port
`timescale 1ns/1ps
`default_nettype none
module mio_ports (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [11:0] bus_addr,
  input wire mio_pkg::mio_width_t bus_width,
  input wire logic [1:0] bus_bit,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic [2:0] port_zero_pins_in,
  output logic [2:0] port_zero_pins_out,
  output logic [2:0] port_zero_pins_oe,
  output logic [2:0] port_zero_pullup,
  input wire logic [1:0] port_one_input_pins,
  output logic [1:0] port_one_pullup,
  input wire logic [3:0] port_two_input_pins,
  input wire logic [2:0] port_three_pins_in,
  output logic [2:0] port_three_pins_out,
  output logic [2:0] port_three_pins_oe,
  output logic [2:0] port_three_pullup,
  input wire logic [3:0] port_four_pins_in,
  output logic [3:0] port_four_pins_out,
  output logic [3:0] port_four_pins_oe,
  output logic [3:0] port_four_pullup,
  input wire logic [3:0] port_five_pins_in,
  output logic [3:0] port_five_pins_out,
  output logic [3:0] port_five_pins_oe,
  output logic [3:0] port_five_pullup,
  input wire logic [3:0] port_six_pins_in,
  output logic [3:0] port_six_pins_out,
  output logic [3:0] port_six_pins_oe,
  output logic [3:0] port_six_pullup
);
  logic [mio_pkg::PIN_IN_W-1:0] pin_raw;
  logic [mio_pkg::PIN_IN_W-1:0] pin_sync;
  logic [2:0] p0_s;
  logic [1:0] p1_s;
  logic [3:0] p2_s;
  logic [2:0] p3_s;
  logic [3:0] p4_s;
  logic [3:0] p5_s;
  logic [3:0] p6_s;
  logic [3:0] regs_r [mio_pkg::NUM_SLOTS];
  logic [3:0] regs_nxt [mio_pkg::NUM_SLOTS];
  logic [3:0] rd_nib [mio_pkg::NUM_SLOTS];
  logic [4:0] lo_slot;
  logic [4:0] hi_slot;
  logic lo_ok;
  logic hi_ok;
  logic is_w1;
  logic is_w4;
  logic is_w8;
  logic pair_ok;
  logic [3:0] lo_nib;
  logic [3:0] hi_nib;
  logic rd_bit;
  logic [7:0] rd_val;
  logic [7:0] rdata_nxt;
  logic [1:0] p1_pu_nxt;

  // Pin inputs are asynchronous to mclk
  assign pin_raw = {port_six_pins_in, port_five_pins_in, port_four_pins_in,
                    port_three_pins_in, port_two_input_pins, port_one_input_pins,
                    port_zero_pins_in};

  mio_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin_raw(pin_raw),
    .pin_sync(pin_sync)
  );

  assign p0_s = pin_sync[mio_pkg::P0_LSB +: mio_pkg::P0_W];
  assign p1_s = pin_sync[mio_pkg::P1_LSB +: mio_pkg::P1_W];
  assign p2_s = pin_sync[mio_pkg::P2_LSB +: mio_pkg::P2_W];
  assign p3_s = pin_sync[mio_pkg::P3_LSB +: mio_pkg::P3_W];
  assign p4_s = pin_sync[mio_pkg::P4_LSB +: mio_pkg::P4_W];
  assign p5_s = pin_sync[mio_pkg::P5_LSB +: mio_pkg::P5_W];
  assign p6_s = pin_sync[mio_pkg::P6_LSB +: mio_pkg::P6_W];

  // Address decode; an 8-bit access names the even nibble and the one above
  assign lo_slot = mio_pkg::addr_slot(bus_addr);
  assign hi_slot = mio_pkg::addr_slot(bus_addr + 12'h001);
  assign lo_ok = (lo_slot != mio_pkg::SLOT_NONE);
  assign hi_ok = (hi_slot != mio_pkg::SLOT_NONE);
  assign is_w1 = (bus_width == mio_pkg::MIO_W1);
  assign is_w4 = (bus_width == mio_pkg::MIO_W4);
  assign is_w8 = (bus_width == mio_pkg::MIO_W8);
  // Among the ports only the four/five pair is byte-wide
  assign pair_ok = is_w8 && !bus_addr[0] && lo_ok && hi_ok &&
                   (lo_slot >= mio_pkg::S_DIR0 || lo_slot == mio_pkg::S_P4);

  // Read view: output pins show the latch, input pins the synchronised level
  assign rd_nib[mio_pkg::S_P0] = mio_pkg::port_rd(regs_r[mio_pkg::S_P0],
      regs_r[mio_pkg::S_DIR0], {1'b0, p0_s}) & mio_pkg::SLOT_MASK[mio_pkg::S_P0];
  assign rd_nib[mio_pkg::S_P1] = {2'h0, p1_s};
  assign rd_nib[mio_pkg::S_P2] = p2_s;
  assign rd_nib[mio_pkg::S_P3] = mio_pkg::port_rd(regs_r[mio_pkg::S_P3],
      regs_r[mio_pkg::S_DIR3], {1'b0, p3_s}) & mio_pkg::SLOT_MASK[mio_pkg::S_P3];
  assign rd_nib[mio_pkg::S_P4] = mio_pkg::port_rd(regs_r[mio_pkg::S_P4],
      regs_r[mio_pkg::S_DIR4], p4_s);
  assign rd_nib[mio_pkg::S_P5] = mio_pkg::port_rd(regs_r[mio_pkg::S_P5],
      regs_r[mio_pkg::S_DIR5], p5_s);
  assign rd_nib[mio_pkg::S_P6] = mio_pkg::port_rd(regs_r[mio_pkg::S_P6],
      regs_r[mio_pkg::S_DIR6], p6_s);

  for (genvar s = 0; s < mio_pkg::NUM_SLOTS; s++) begin : g_slot
    logic wr_lo;
    logic wr_hi;
    if (s >= 7) begin : g_cfg
      assign rd_nib[s] = regs_r[s];
    end
    // Masked bits never store, so input-only slots stay empty
    assign wr_lo = bus_wr && lo_ok && (lo_slot == 5'(s)) && (!is_w8 || pair_ok);
    assign wr_hi = bus_wr && pair_ok && (hi_slot == 5'(s));
    assign regs_nxt[s] = wr_lo ? mio_pkg::apply_write(regs_r[s], bus_width, bus_bit,
                                   bus_wdata[3:0], mio_pkg::SLOT_MASK[s]) :
                         wr_hi ? mio_pkg::apply_write(regs_r[s], mio_pkg::MIO_W4, bus_bit,
                                   bus_wdata[7:4], mio_pkg::SLOT_MASK[s]) :
                         regs_r[s];
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < mio_pkg::NUM_SLOTS; i++) begin
      if (sys_rst) begin
        regs_r[i] <= mio_pkg::REG_RST;
      end else begin
        regs_r[i] <= regs_nxt[i];
      end
    end
  end

  // Bit test returns the selected bit in bit 0
  assign lo_nib = lo_ok ? rd_nib[lo_slot] : 4'h0;
  assign hi_nib = hi_ok ? rd_nib[hi_slot] : 4'h0;
  assign rd_bit = lo_nib[bus_bit];
  assign rd_val = is_w1 ? {7'h00, rd_bit} :
                  is_w4 ? {4'h0, lo_nib} :
                  pair_ok ? {hi_nib, lo_nib} : 8'h00;
  // Read data stand for one cycle only, zero otherwise
  assign rdata_nxt = bus_rd ? rd_val : 8'h00;
  assign p1_pu_nxt = regs_r[mio_pkg::S_PU1][1:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_rdata <= 8'h00;
      port_one_pullup <= 2'h0;
    end else begin
      bus_rdata <= rdata_nxt;
      port_one_pullup <= p1_pu_nxt;
    end
  end

  mio_pin_drv #(.W(mio_pkg::P0_W)) u_drv0 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .latch(regs_r[mio_pkg::S_P0][2:0]),
    .dir(regs_r[mio_pkg::S_DIR0][2:0]),
    .pu_sel(regs_r[mio_pkg::S_PU0][2:0]),
    .od_sel(3'h0),
    .pin_out(port_zero_pins_out),
    .pin_oe(port_zero_pins_oe),
    .pu_out(port_zero_pullup)
  );

  mio_pin_drv #(.W(mio_pkg::P3_W)) u_drv3 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .latch(regs_r[mio_pkg::S_P3][2:0]),
    .dir(regs_r[mio_pkg::S_DIR3][2:0]),
    .pu_sel(regs_r[mio_pkg::S_PU3][2:0]),
    .od_sel(3'h0),
    .pin_out(port_three_pins_out),
    .pin_oe(port_three_pins_oe),
    .pu_out(port_three_pullup)
  );

  mio_pin_drv #(.W(mio_pkg::P4_W)) u_drv4 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .latch(regs_r[mio_pkg::S_P4]),
    .dir(regs_r[mio_pkg::S_DIR4]),
    .pu_sel({4{regs_r[mio_pkg::S_PU45][mio_pkg::PU45_GRP4_BIT]}}),
    .od_sel(regs_r[mio_pkg::S_OD4]),
    .pin_out(port_four_pins_out),
    .pin_oe(port_four_pins_oe),
    .pu_out(port_four_pullup)
  );

  mio_pin_drv #(.W(mio_pkg::P5_W)) u_drv5 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .latch(regs_r[mio_pkg::S_P5]),
    .dir(regs_r[mio_pkg::S_DIR5]),
    .pu_sel({4{regs_r[mio_pkg::S_PU45][mio_pkg::PU45_GRP5_BIT]}}),
    .od_sel(regs_r[mio_pkg::S_OD5]),
    .pin_out(port_five_pins_out),
    .pin_oe(port_five_pins_oe),
    .pu_out(port_five_pullup)
  );

  mio_pin_drv #(.W(mio_pkg::P6_W)) u_drv6 (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .latch(regs_r[mio_pkg::S_P6]),
    .dir(regs_r[mio_pkg::S_DIR6]),
    .pu_sel(regs_r[mio_pkg::S_PU6]),
    .od_sel(4'h0),
    .pin_out(port_six_pins_out),
    .pin_oe(port_six_pins_oe),
    .pu_out(port_six_pullup)
  );

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  logic [3:0] chk_p4_exp;
  logic [3:0] chk_p5_exp;
  logic [7:0] chk_pair_exp;
  logic [7:0] chk_outs;
  assign chk_p4_exp = (regs_r[mio_pkg::S_DIR4] & regs_r[mio_pkg::S_P4]) |
                      (~regs_r[mio_pkg::S_DIR4] & p4_s);
  assign chk_p5_exp = (regs_r[mio_pkg::S_DIR5] & regs_r[mio_pkg::S_P5]) |
                      (~regs_r[mio_pkg::S_DIR5] & p5_s);
  // Expected views come from registers and pins, not from the read mux
  assign chk_pair_exp = {chk_p5_exp, chk_p4_exp};
  assign chk_outs = {port_four_pins_oe, port_six_pins_oe};

  chk_port_map: assert property (bus_rd && is_w4 && bus_addr == mio_pkg::ADDR_PORT2
      |=> bus_rdata == {4'h0, $past(p2_s)})
    else $error("port two read not mapped at its address");
  chk_dir_rdback: assert property (bus_wr && is_w4 && bus_addr == mio_pkg::ADDR_DIR6
      ##1 bus_rd && is_w4 && bus_addr == mio_pkg::ADDR_DIR6
      |=> bus_rdata[3:0] == $past(bus_wdata[3:0], 2))
    else $error("written nibble not read back");
  chk_p0_width: assert property (bus_rd && is_w4 && bus_addr == mio_pkg::ADDR_PORT0
      |=> bus_rdata[7:3] == 5'h00)
    else $error("port zero read wider than three bits");
  chk_pullup_off: assert property ((port_six_pullup & port_six_pins_oe) == 4'h0 &&
      (port_zero_pullup & port_zero_pins_oe) == 3'h0)
    else $error("pull-up active on a driven pin");
  chk_dir_oe: assert property (##1 port_six_pins_oe == $past(regs_r[mio_pkg::S_DIR6]))
    else $error("port six enable does not follow direction");
  chk_p1_input: assert property (bus_rd && is_w4 && bus_addr == mio_pkg::ADDR_PORT1
      |=> bus_rdata == {6'h00, $past(p1_s)})
    else $error("port one read wrong");
  chk_p2_nowrite: assert property (bus_wr && bus_addr == mio_pkg::ADDR_PORT2 ##1 !bus_wr
      |=> $stable(chk_outs))
    else $error("write to input port changed outputs");
  chk_byte_pair: assert property (bus_rd && is_w8 && bus_addr == mio_pkg::ADDR_PORT4
      |=> bus_rdata == $past(chk_pair_exp))
    else $error("byte read of ports four and five wrong");
  chk_group_pu: assert property (##1 port_four_pullup ==
      ({4{$past(regs_r[mio_pkg::S_PU45][mio_pkg::PU45_GRP4_BIT])}} &
       ~$past(regs_r[mio_pkg::S_DIR4])))
    else $error("port four group pull-up wrong");
  chk_od_drive: assert property (##1 port_five_pins_oe ==
      $past(regs_r[mio_pkg::S_DIR5] & ~(regs_r[mio_pkg::S_OD5] & regs_r[mio_pkg::S_P5])))
    else $error("port five open-drain enable wrong");
  chk_p6_bitwr: assert property (bus_wr && is_w1 && bus_addr == mio_pkg::ADDR_PORT6
      |=> regs_r[mio_pkg::S_P6][$past(bus_bit)] == $past(bus_wdata[0]))
    else $error("port six bit write lost");
  chk_rst_quiet: assert property ($fell(sys_rst) |-> chk_outs == 8'h00 &&
      port_zero_pins_oe == 3'h0 && port_five_pullup == 4'h0 [*2])
    else $error("pins not quiet after reset");
  chk_rd_source: assert property (bus_rd && is_w4 && bus_addr == mio_pkg::ADDR_PORT4
      |=> bus_rdata == {4'h0, $past(chk_p4_exp)})
    else $error("port four read source wrong");
  chk_unmap_rd: assert property (bus_rd && bus_addr == mio_pkg::ADDR_PORT6 + 12'h001
      |=> bus_rdata == 8'h00)
    else $error("unmapped address read not zero");
  chk_rdata_idle: assert property (!bus_rd |=> bus_rdata == 8'h00)
    else $error("read data not zero outside a read");
  chk_p0_oe: assert property (##1 port_zero_pins_oe ==
      $past(regs_r[mio_pkg::S_DIR0][2:0]))
    else $error("port zero enable does not follow direction");
  chk_p1_pullup: assert property (##1 port_one_pullup ==
      $past(regs_r[mio_pkg::S_PU1][1:0]))
    else $error("port one pull-up does not follow its register");
  chk_p2_bit: assert property (bus_rd && is_w1 && bus_addr == mio_pkg::ADDR_PORT2
      |=> bus_rdata == {7'h00, $past(p2_s[bus_bit])})
    else $error("port two bit test wrong");
  chk_p3_pu_off: assert property ((port_three_pullup & port_three_pins_oe) == 3'h0)
    else $error("port three pull-up on a driven pin");
  chk_p45_pu_off: assert property (((port_four_pullup & port_four_pins_oe) |
      (port_five_pullup & port_five_pins_oe)) == 4'h0)
    else $error("port four or five pull-up on a driven pin");
  chk_p4_od_out: assert property (##1 port_four_pins_out ==
      $past(regs_r[mio_pkg::S_P4] & ~regs_r[mio_pkg::S_OD4]))
    else $error("port four open-drain output value wrong");

  cov_byte_rd: cover property (bus_rd && pair_ok ##1 bus_rdata != 8'h00);
  cov_bit_wr: cover property (bus_wr && is_w1 && bus_addr == mio_pkg::ADDR_PORT6);
  cov_p2_bit: cover property (bus_rd && is_w1 && bus_addr == mio_pkg::ADDR_PORT2);
  cov_pu_mix: cover property (port_six_pullup != 4'h0 && port_six_pins_oe != 4'h0);
  cov_od_rel: cover property (port_five_pins_out == 4'h0 && port_five_pins_oe == 4'h0 &&
      regs_r[mio_pkg::S_DIR5] == 4'hF);
endmodule : mio_ports
`default_nettype wire

// [mio_board.sv]
// Board-side model of the external lines on one port
`timescale 1ns/1ps
`default_nettype none
module mio_board #(
  parameter int W = 4
) (
  input wire logic mclk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] ext_e,
  input wire logic [W-1:0] ext_v,
  output logic [W-1:0] lvl
);
  logic [W-1:0] flip_r = '0;
  // A floating line with no pull-up must not hold a stale level
  always @(posedge mclk) begin
    flip_r <= ~flip_r;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) begin
        lvl[i] = out[i];
      end else if (ext_e[i]) begin
        lvl[i] = ext_v[i];
      end else if (pu[i]) begin
        lvl[i] = 1'b1;
      end else begin
        lvl[i] = flip_r[i];
      end
    end
  end
endmodule : mio_board
`default_nettype wire

// [mio_ports_tb.sv]
// Self-checking testbench for the memory-mapped port block
`timescale 1ns/1ps
`default_nettype none
module mio_ports_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [11:0] bus_addr = 12'h000;
  mio_pkg::mio_width_t bus_width = mio_pkg::MIO_W4;
  logic [1:0] bus_bit = 2'h0;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic [23:0] ext_v = 24'h000000;
  logic [23:0] ext_e = 24'hFFFFFF;
  logic [2:0] p0_in, p0_out, p0_oe, p0_pu, p3_in, p3_out, p3_oe, p3_pu;
  logic [1:0] p1_in, p1_pu;
  logic [3:0] p2_in, p4_in, p4_out, p4_oe, p4_pu, p5_in, p5_out, p5_oe, p5_pu;
  logic [3:0] p6_in, p6_out, p6_oe, p6_pu, d;
  logic [7:0] d8;
  logic [5:0] p12_lvl;
  logic [11:0] ap;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  logic [17:0] all_oe;
  logic [19:0] all_pu;
  assign all_oe = {p6_oe, p5_oe, p4_oe, p3_oe, p0_oe};
  assign all_pu = {p6_pu, p5_pu, p4_pu, p3_pu, p1_pu, p0_pu};

  always #2 mclk = ~mclk;

  mio_ports i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_width(bus_width),
    .bus_bit(bus_bit), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .port_zero_pins_in(p0_in), .port_zero_pins_out(p0_out),
    .port_zero_pins_oe(p0_oe), .port_zero_pullup(p0_pu), .port_one_input_pins(p1_in),
    .port_one_pullup(p1_pu), .port_two_input_pins(p2_in), .port_three_pins_in(p3_in),
    .port_three_pins_out(p3_out), .port_three_pins_oe(p3_oe), .port_three_pullup(p3_pu),
    .port_four_pins_in(p4_in), .port_four_pins_out(p4_out), .port_four_pins_oe(p4_oe),
    .port_four_pullup(p4_pu), .port_five_pins_in(p5_in), .port_five_pins_out(p5_out),
    .port_five_pins_oe(p5_oe), .port_five_pullup(p5_pu), .port_six_pins_in(p6_in),
    .port_six_pins_out(p6_out), .port_six_pins_oe(p6_oe), .port_six_pullup(p6_pu)
  );

  mio_board #(.W(3)) i_b0 (.mclk(mclk), .out(p0_out), .oe(p0_oe), .pu(p0_pu),
    .ext_e(ext_e[2:0]), .ext_v(ext_v[2:0]), .lvl(p0_in));
  // Ports one and two share one model; the block never drives them
  mio_board #(.W(6)) i_b12 (.mclk(mclk), .out(6'h00), .oe(6'h00), .pu({4'h0, p1_pu}),
    .ext_e(ext_e[8:3]), .ext_v(ext_v[8:3]), .lvl(p12_lvl));
  assign {p2_in, p1_in} = p12_lvl;
  mio_board #(.W(3)) i_b3 (.mclk(mclk), .out(p3_out), .oe(p3_oe), .pu(p3_pu),
    .ext_e(ext_e[11:9]), .ext_v(ext_v[11:9]), .lvl(p3_in));
  mio_board #(.W(4)) i_b4 (.mclk(mclk), .out(p4_out), .oe(p4_oe), .pu(p4_pu),
    .ext_e(ext_e[15:12]), .ext_v(ext_v[15:12]), .lvl(p4_in));
  mio_board #(.W(4)) i_b5 (.mclk(mclk), .out(p5_out), .oe(p5_oe), .pu(p5_pu),
    .ext_e(ext_e[19:16]), .ext_v(ext_v[19:16]), .lvl(p5_in));
  mio_board #(.W(4)) i_b6 (.mclk(mclk), .out(p6_out), .oe(p6_oe), .pu(p6_pu),
    .ext_e(ext_e[23:20]), .ext_v(ext_v[23:20]), .lvl(p6_in));

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  // Strobes are left up so back-to-back accesses need no gap
  task automatic op(input logic w, input logic r, input logic [11:0] a, input logic [7:0] dt,
                    input mio_pkg::mio_width_t wd, input logic [1:0] b);
    bus_wr <= w;
    bus_rd <= r;
    bus_addr <= a;
    bus_wdata <= dt;
    bus_width <= wd;
    bus_bit <= b;
    @(posedge mclk);
  endtask : op

  task automatic wr(input logic [11:0] a, input logic [7:0] dt,
                    input mio_pkg::mio_width_t wd = mio_pkg::MIO_W4, input logic [1:0] b = 2'h0);
    op(1'b1, 1'b0, a, dt, wd, b);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input mio_pkg::mio_width_t wd = mio_pkg::MIO_W4, input logic [1:0] b = 2'h0);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00, wd, b);
  endtask : rd

  task automatic idle(input int n);
    bus_wr <= 1'b0;
    bus_rd <= 1'b0;
    repeat (n) @(posedge mclk);
  endtask : idle

  always @(posedge mclk) begin
    rd_pend <= bus_rd;
  end
  always @(negedge mclk) begin
    if (rd_pend) begin
      chk(24'(bus_rdata), 24'(exp_q.pop_front()));
    end else if (!sys_rst) begin
      chk(24'(bus_rdata), 24'h0);
    end
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    void'($urandom(27508));
    ext_v <= 24'($urandom);
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    idle(3);
    chk(24'(all_oe), 24'h0);
    chk(24'(all_pu), 24'h0);
    for (int a = 0; a < 12; a++) begin
      rd(mio_pkg::ADDR_DIR0 + 12'(a), 8'h00);
    end
    $display("test reset done");
    d = 4'($urandom);
    wr(mio_pkg::ADDR_DIR6, 8'h0F);
    rd(mio_pkg::ADDR_DIR6, 8'h0F);
    wr(mio_pkg::ADDR_PORT6, {4'h0, d});
    idle(2);
    chk(24'(p6_out), 24'(d));
    chk(24'(p6_oe), 24'hF);
    rd(mio_pkg::ADDR_PORT6, {4'h0, d});
    for (int b = 0; b < 4; b++) begin
      wr(mio_pkg::ADDR_PORT6, {7'h00, !d[b]}, mio_pkg::MIO_W1, 2'(b));
      rd(mio_pkg::ADDR_PORT6, {7'h00, !d[b]}, mio_pkg::MIO_W1, 2'(b));
    end
    // Pin 3 left to its pull-up alone
    ext_e <= 24'h7FFFFF;
    wr(mio_pkg::ADDR_DIR6, 8'h03);
    wr(mio_pkg::ADDR_PU6, 8'h0F);
    idle(4);
    chk(24'(p6_pu), 24'hC);
    rd(mio_pkg::ADDR_PORT6, {4'h0, 1'b1, ext_v[22], ~d[1:0]});
    $display("test port six done");
    for (int p = 0; p < 2; p++) begin
      d = 4'($urandom);
      ap = p ? mio_pkg::ADDR_PORT3 : mio_pkg::ADDR_PORT0;
      wr(p ? mio_pkg::ADDR_DIR3 : mio_pkg::ADDR_DIR0, 8'h05);
      wr(p ? mio_pkg::ADDR_PU3 : mio_pkg::ADDR_PU0, 8'h0F);
      wr(ap, {4'h0, d});
      idle(2);
      chk(24'(p ? p3_pu : p0_pu), 24'h2);
      chk(24'(p ? p3_oe : p0_oe), 24'h5);
      chk(24'(p ? p3_out : p0_out), 24'(d[2:0]));
      rd(ap, {5'h00, d[2], ext_v[p ? 10 : 1], d[0]});
      rd(ap, {7'h00, ext_v[p ? 10 : 1]}, mio_pkg::MIO_W1, 2'h1);
      rd(ap, 8'h00, mio_pkg::MIO_W1, 2'h3);
    end
    $display("test ports zero three done");
    wr(mio_pkg::ADDR_PU1, 8'h0F);
    wr(mio_pkg::ADDR_PORT2, {4'h0, ~ext_v[8:5]});
    idle(2);
    chk(24'(p1_pu), 24'h3);
    rd(mio_pkg::ADDR_PORT1, {6'h00, ext_v[4:3]});
    rd(mio_pkg::ADDR_PORT1, {7'h00, ext_v[4]}, mio_pkg::MIO_W1, 2'h1);
    rd(mio_pkg::ADDR_PORT2, {4'h0, ext_v[8:5]});
    rd(mio_pkg::ADDR_PORT2, {7'h00, ext_v[8]}, mio_pkg::MIO_W1, 2'h3);
    $display("test input ports done");
    d8 = 8'($urandom);
    wr(mio_pkg::ADDR_DIR4, 8'h30, mio_pkg::MIO_W8);
    wr(mio_pkg::ADDR_PU45, 8'h03);
    wr(mio_pkg::ADDR_PORT4, d8, mio_pkg::MIO_W8);
    idle(2);
    chk(24'({p5_pu, p4_pu}), 24'hCF);
    rd(mio_pkg::ADDR_PORT4, {ext_v[19:18], d8[5:4], ext_v[15:12]}, mio_pkg::MIO_W8);
    wr(mio_pkg::ADDR_DIR4, 8'hFF, mio_pkg::MIO_W8);
    wr(mio_pkg::ADDR_OD4, 8'h5A, mio_pkg::MIO_W8);
    idle(2);
    chk(24'({p5_pu, p4_pu}), 24'h0);
    chk(24'({p5_out, p4_out}), 24'(d8 & 8'hA5));
    chk(24'({p5_oe, p4_oe}), {16'h0000, ~(d8 & 8'h5A)});
    rd(mio_pkg::ADDR_PORT4, d8, mio_pkg::MIO_W8);
    wr(mio_pkg::ADDR_PORT5, {7'h00, !d8[6]}, mio_pkg::MIO_W1, 2'h2);
    rd(mio_pkg::ADDR_PORT5, {4'h0, d8[7], !d8[6], d8[5:4]});
    rd(mio_pkg::ADDR_PORT4, {4'h0, d8[3:0]});
    $display("test ports four five done");
    rd(12'hFF7, 8'h00);
    rd(12'hEF0, 8'h00);
    rd(mio_pkg::ADDR_PORT5, 8'h00, mio_pkg::MIO_W8);
    sys_rst <= 1'b1;
    idle(2);
    sys_rst <= 1'b0;
    idle(3);
    chk(24'(all_oe), 24'h0);
    chk(24'(all_pu), 24'h0);
    rd(mio_pkg::ADDR_PORT4, ext_v[19:12], mio_pkg::MIO_W8);
    idle(3);
    $display("test decode and second reset done");
    close_out();
  end
endmodule : mio_ports_tb
`default_nettype wire
